// ==== verilog/pmm_pkg.sv ====
// constants, types and state codes of the paged management memory
`default_nettype none
package pmm_pkg;
  // serial bus address the memory answers at
  localparam logic [6:0] DEV_ADDR = 7'h50;
  // region sizes
  localparam int LOWER_BYTES = 128;
  localparam int PAGE_BYTES = 128;
  localparam int NUM_SLOTS = 5;
  localparam int UPPER_BIT = 7;
  // lower-region control bytes
  localparam logic [6:0] PAGE_SEL_OFS = 7'h7f;
  localparam logic [6:0] BANK_SEL_OFS = 7'h7e;
  localparam logic [6:0] INT_FLAG_OFS = 7'h03;
  // implemented pages and bank
  localparam logic [7:0] PG_00 = 8'h00;
  localparam logic [7:0] PG_01 = 8'h01;
  localparam logic [7:0] PG_02 = 8'h02;
  localparam logic [7:0] PG_10 = 8'h10;
  localparam logic [7:0] PG_11 = 8'h11;
  localparam logic [7:0] BANK_0 = 8'h00;
  // storage slots of the implemented pages
  localparam logic [2:0] SLOT_00 = 3'h0;
  localparam logic [2:0] SLOT_01 = 3'h1;
  localparam logic [2:0] SLOT_02 = 3'h2;
  localparam logic [2:0] SLOT_10 = 3'h3;
  localparam logic [2:0] SLOT_11 = 3'h4;
  // bit counter end and fill value
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] BLANK_BYTE = 8'h00;
  // synchroniser lanes
  localparam int SYNC_W = 4;
  localparam int LN_SCL = 0;
  localparam int LN_SDA = 1;
  localparam int LN_LPW = 2;
  localparam int LN_RSTN = 3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b010,
    ST_OFFS = 3'b011,
    ST_WDATA = 3'b100,
    ST_WACK = 3'b101,
    ST_RDATA = 3'b110,
    ST_RACK = 3'b111
  } pmm_state_type;

  // 2-wire pins as seen by the module
  typedef struct packed {
    logic scl;
    logic sda;
  } pmm_wire_in_type;

  // host side of the two multi-level sideband lines
  typedef struct packed {
    logic low_power_req;
    logic reset_n;
  } pmm_side_in_type;

  // module side of the two multi-level sideband lines
  typedef struct packed {
    logic present;
    logic int_req;
    logic low_power_mode;
    logic module_reset;
  } pmm_side_out_type;
endpackage : pmm_pkg
`default_nettype wire

// ==== verilog/pmm_paged_mem.sv ====
// paged management memory behind a 2-wire slave with sideband lines
`timescale 1ns/1ns
`default_nettype none
module pmm_paged_mem #(
  parameter bit PAGED = 1'b1
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire pmm_pkg::pmm_wire_in_type i_wire,
  input wire pmm_pkg::pmm_side_in_type i_side,
  input wire logic i_int_event,
  output logic o_sda_out,
  output logic o_sda_oe,
  output pmm_pkg::pmm_side_out_type o_side
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [pmm_pkg::SYNC_W-1:0] sync1;
  logic [pmm_pkg::SYNC_W-1:0] sync2;
  logic [pmm_pkg::SYNC_W-1:0] prev;
  logic [pmm_pkg::SYNC_W-1:0] raw_in;

  assign raw_in = {i_side.reset_n, i_side.low_power_req,
                   i_wire.sda, i_wire.scl};

  // two stages, then one more for edge finding
  always_ff @(posedge i_clk_sys)
  begin
    sync1 <= raw_in;
    sync2 <= sync1;
    prev <= sync2;
  end

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  assign scl = sync2[pmm_pkg::LN_SCL];
  assign sda = sync2[pmm_pkg::LN_SDA];
  assign scl_rise = scl & ~prev[pmm_pkg::LN_SCL];
  assign scl_fall = ~scl & prev[pmm_pkg::LN_SCL];
  assign start_cond = scl & prev[pmm_pkg::LN_SCL] &
                      ~sda & prev[pmm_pkg::LN_SDA];
  assign stop_cond = scl & prev[pmm_pkg::LN_SCL] &
                     sda & ~prev[pmm_pkg::LN_SDA];

  // ----------------------------------------------------------------
  // sideband lines and internal reset
  // ----------------------------------------------------------------
  logic host_reset;
  logic int_flag;
  logic next_int_flag;
  logic int_clear;
  logic core_rst;

  // host holding the shared line low resets the module
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      host_reset <= 1'b0;
    else
      host_reset <= ~sync2[pmm_pkg::LN_RSTN];
  end

  assign core_rst = i_rst | host_reset;

  // sticky interrupt flag, a new event beats the clear
  always_comb
  begin
    next_int_flag = int_flag;
    if (int_clear)
      next_int_flag = 1'b0;
    if (i_int_event)
      next_int_flag = 1'b1;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (core_rst)
      int_flag <= 1'b0;
    else
      int_flag <= next_int_flag;
  end

  // sideband outputs, all from flops
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      o_side <= '0;
    else
    begin
      o_side.present <= 1'b1;
      o_side.low_power_mode <= sync2[pmm_pkg::LN_LPW];
      o_side.int_req <= next_int_flag;
      o_side.module_reset <= host_reset;
    end
  end

  // ----------------------------------------------------------------
  // storage: lower region and implemented pages
  // ----------------------------------------------------------------
  logic [7:0] lower [pmm_pkg::LOWER_BYTES];
  logic [7:0] pages [pmm_pkg::NUM_SLOTS][pmm_pkg::PAGE_BYTES];
  logic [7:0] next_lower [pmm_pkg::LOWER_BYTES];
  logic [7:0] next_pages [pmm_pkg::NUM_SLOTS][pmm_pkg::PAGE_BYTES];
  logic [2:0] sel_slot;
  logic sel_valid;

  // map the selected page and bank onto a storage slot
  always_comb
  begin
    sel_slot = pmm_pkg::SLOT_00;
    sel_valid = 1'b1;
    if (PAGED)
    begin
      case (lower[pmm_pkg::PAGE_SEL_OFS])
        pmm_pkg::PG_00: sel_slot = pmm_pkg::SLOT_00;
        pmm_pkg::PG_01: sel_slot = pmm_pkg::SLOT_01;
        pmm_pkg::PG_02: sel_slot = pmm_pkg::SLOT_02;
        pmm_pkg::PG_10: sel_slot = pmm_pkg::SLOT_10;
        pmm_pkg::PG_11: sel_slot = pmm_pkg::SLOT_11;
        default: sel_valid = 1'b0;
      endcase
      // lane pages exist per bank; only bank 0 is built
      if (lower[pmm_pkg::PAGE_SEL_OFS] >= pmm_pkg::PG_10 &&
          lower[pmm_pkg::BANK_SEL_OFS] != pmm_pkg::BANK_0)
        sel_valid = 1'b0;
    end
  end

  // one byte seen by the host at a given address
  function automatic logic [7:0] host_byte(input logic [7:0] addr,
                                           input logic [2:0] slot,
                                           input logic valid,
                                           input logic flag);
    logic [7:0] b;
    b = pmm_pkg::BLANK_BYTE;
    if (!addr[pmm_pkg::UPPER_BIT])
    begin
      b = lower[addr[6:0]];
      if (addr[6:0] == pmm_pkg::INT_FLAG_OFS)
        b[0] = flag;
    end
    else if (valid)
      b = pages[slot][addr[6:0]];
    return b;
  endfunction : host_byte

  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;

  // byte write into lower region or selected page
  always_comb
  begin
    next_lower = lower;
    next_pages = pages;
    if (wr_en)
    begin
      if (!wr_addr[pmm_pkg::UPPER_BIT])
        next_lower[wr_addr[6:0]] = wr_data;
      else if (sel_valid)
        next_pages[sel_slot][wr_addr[6:0]] = wr_data;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (core_rst)
    begin
      for (int i = 0; i < pmm_pkg::LOWER_BYTES; i++)
        lower[i] <= pmm_pkg::BLANK_BYTE;
      for (int s = 0; s < pmm_pkg::NUM_SLOTS; s++)
        for (int j = 0; j < pmm_pkg::PAGE_BYTES; j++)
          pages[s][j] <= pmm_pkg::BLANK_BYTE;
    end
    else
    begin
      lower <= next_lower;
      pages <= next_pages;
    end
  end

  // ----------------------------------------------------------------
  // 2-wire slave state machine
  // ----------------------------------------------------------------
  pmm_pkg::pmm_state_type state;
  pmm_pkg::pmm_state_type next_state;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] ptr;
  logic [7:0] next_ptr;
  logic rw;
  logic next_rw;
  logic byte_full;
  logic next_byte_full;
  logic next_sda_oe;
  logic [7:0] load_byte;
  logic [7:0] load_addr;

  assign wr_addr = ptr;
  assign wr_data = shreg;

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_shreg = shreg;
    next_ptr = ptr;
    next_rw = rw;
    next_byte_full = byte_full;
    next_sda_oe = o_sda_oe;
    wr_en = 1'b0;
    int_clear = 1'b0;
    load_addr = ptr;
    load_byte = pmm_pkg::BLANK_BYTE;
    if (start_cond)
    begin
      next_state = pmm_pkg::ST_ADDR;
      next_cnt = '0;
      next_byte_full = 1'b0;
      next_sda_oe = 1'b0;
    end
    else if (stop_cond)
    begin
      next_state = pmm_pkg::ST_IDLE;
      next_sda_oe = 1'b0;
    end
    else
    begin
      case (state)
        pmm_pkg::ST_ADDR, pmm_pkg::ST_OFFS, pmm_pkg::ST_WDATA:
        begin
          if (scl_rise && !byte_full)
          begin
            next_shreg = {shreg[6:0], sda};
            next_cnt = cnt + 3'h1;
            if (cnt == pmm_pkg::BIT_LAST)
              next_byte_full = 1'b1;
          end
          else if (scl_fall && byte_full)
          begin
            next_byte_full = 1'b0;
            next_sda_oe = 1'b1;
            if (state == pmm_pkg::ST_ADDR)
            begin
              // answer at the one bus address only
              if (shreg[7:1] == pmm_pkg::DEV_ADDR)
              begin
                next_rw = shreg[0];
                next_state = pmm_pkg::ST_AACK;
              end
              else
              begin
                next_sda_oe = 1'b0;
                next_state = pmm_pkg::ST_IDLE;
              end
            end
            else if (state == pmm_pkg::ST_OFFS)
            begin
              next_ptr = shreg;
              next_state = pmm_pkg::ST_WACK;
            end
            else
            begin
              wr_en = 1'b1;
              next_ptr = ptr + 8'h01;
              next_state = pmm_pkg::ST_WACK;
            end
          end
        end
        pmm_pkg::ST_AACK, pmm_pkg::ST_WACK:
        begin
          if (scl_fall)
          begin
            next_cnt = '0;
            next_sda_oe = 1'b0;
            if (state == pmm_pkg::ST_WACK)
              next_state = pmm_pkg::ST_WDATA;
            else if (!rw)
              next_state = pmm_pkg::ST_OFFS;
            else
            begin
              // first read byte at the current pointer
              load_byte = host_byte(load_addr, sel_slot, sel_valid,
                                    int_flag);
              int_clear = (load_addr == {1'b0, pmm_pkg::INT_FLAG_OFS});
              next_shreg = load_byte;
              next_sda_oe = ~load_byte[7];
              next_state = pmm_pkg::ST_RDATA;
            end
          end
        end
        pmm_pkg::ST_RDATA:
        begin
          if (scl_fall)
          begin
            next_cnt = cnt + 3'h1;
            next_shreg = {shreg[6:0], 1'b0};
            // all eight bits shown: release for the host's answer bit
            if (cnt == pmm_pkg::BIT_LAST)
            begin
              next_sda_oe = 1'b0;
              next_state = pmm_pkg::ST_RACK;
            end
            else
              next_sda_oe = ~shreg[6];
          end
        end
        pmm_pkg::ST_RACK:
        begin
          if (scl_rise)
          begin
            if (sda)
              next_state = pmm_pkg::ST_IDLE;
            else
              next_byte_full = 1'b1;
          end
          else if (scl_fall && byte_full)
          begin
            // host acknowledged: next byte
            next_byte_full = 1'b0;
            load_addr = ptr + 8'h01;
            next_ptr = load_addr;
            load_byte = host_byte(load_addr, sel_slot, sel_valid,
                                  int_flag);
            int_clear = (load_addr == {1'b0, pmm_pkg::INT_FLAG_OFS});
            next_shreg = load_byte;
            next_sda_oe = ~load_byte[7];
            next_cnt = '0;
            next_state = pmm_pkg::ST_RDATA;
          end
        end
        pmm_pkg::ST_IDLE:
        begin
          next_sda_oe = 1'b0;
        end
        default:
        begin
          next_state = pmm_pkg::ST_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (core_rst)
    begin
      state <= pmm_pkg::ST_IDLE;
      cnt <= '0;
      shreg <= '0;
      ptr <= '0;
      rw <= 1'b0;
      byte_full <= 1'b0;
      o_sda_oe <= 1'b0;
      o_sda_out <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      shreg <= next_shreg;
      ptr <= next_ptr;
      rw <= next_rw;
      byte_full <= next_byte_full;
      o_sda_oe <= next_sda_oe; // open drain: only ever pulls low
      o_sda_out <= 1'b0;
    end
  end

endmodule : pmm_paged_mem
`default_nettype wire

// ==== tb/pmm_assertions.sv ====
// concurrent checks on the paged management memory ports
`timescale 1ns/1ns
`default_nettype none
module pmm_assertions (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire pmm_pkg::pmm_wire_in_type i_wire,
  input wire pmm_pkg::pmm_side_in_type i_side,
  input wire logic i_int_event,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire pmm_pkg::pmm_side_out_type o_side
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  // open drain: the data output never drives high
  chk_sda_low_only: assert property (o_sda_out == 1'b0)
    else $error("data output driven high");
  // ack or data starts only after the clock went low
  chk_ack_after_fall: assert property ($rose(o_sda_oe) |->
    !$past(i_wire.scl, 3)) else $error("data driven without clock low");
  // data drive stands while the clock stays high
  chk_oe_stands: assert property (i_wire.scl && $past(i_wire.scl)
    |-> $stable(o_sda_oe)) else $error("data drive moved, clock high");
  // presence shown from the first edge after reset
  chk_present_on: assert property (!i_rst |=> o_side.present)
    else $error("presence missing");
  // low power follows the host request
  chk_lp_follow: assert property ($stable(i_side.low_power_req)[*3]
    |=> o_side.low_power_mode == $past(i_side.low_power_req))
    else $error("low power mode wrong");
  // module reset follows the host reset line
  chk_hreset_follow: assert property ($stable(i_side.reset_n)[*3]
    |=> o_side.module_reset == !$past(i_side.reset_n))
    else $error("module reset wrong");
  // an event raises the request on the next edge
  chk_int_raise: assert property (i_side.reset_n[*4] ##0 i_int_event
    |=> o_side.int_req) else $error("interrupt not raised");
  // request is sticky while the bus is quiet
  chk_int_hold: assert property ((o_side.int_req && i_side.reset_n &&
    $stable(i_wire))[*6] |=> o_side.int_req) else $error("interrupt lost");
endmodule : pmm_assertions
bind pmm_paged_mem pmm_assertions pmm_assertions_inst (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_wire(i_wire), .i_side(i_side),
  .i_int_event(i_int_event), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
  .o_side(o_side));
`default_nettype wire

// ==== tb/pmm_host.sv ====
// host controller model of the 2-wire management bus
`timescale 1ns/1ns
`default_nettype none
module pmm_host (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_pull
);
  // bus idle: clock stands high, data released
  initial
  begin
    o_scl = 1'b1;
    o_pull = 1'b0;
  end
  task automatic q(input int n);
    repeat (n) @(negedge i_clk);
  endtask : q
  // start or repeated start: data falls with clock high
  task automatic start();
    o_pull = 1'b0;
    q(2);
    o_scl = 1'b1;
    q(2);
    o_pull = 1'b1;
    q(2);
    o_scl = 1'b0;
    q(2);
  endtask : start
  // one clock: drive b (1 releases), sample line halfway through high phase
  task automatic clk_bit(input logic b, output logic r);
    o_pull = !b;
    q(2);
    o_scl = 1'b1;
    q(2);
    r = i_sda;
    q(2);
    o_scl = 1'b0;
    q(2);
  endtask : clk_bit
  // byte out msb first, then the acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      clk_bit(d[i], r);
    clk_bit(1'b1, r);
    ack = !r;
  endtask : wbyte
  // byte in msb first, then ack or nack
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      clk_bit(1'b1, d[i]);
    clk_bit(!ack, r);
  endtask : rbyte
  // stop: data rises with clock high
  task automatic stop();
    o_pull = 1'b1;
    q(2);
    o_scl = 1'b1;
    q(2);
    o_pull = 1'b0;
    q(4);
  endtask : stop
endmodule : pmm_host
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench of the paged management memory
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic i_int_event = 1'b0;
  logic scl, pull, sda, o_sda_out, o_sda_oe;
  logic sda_flat, oe_flat, host_sda;
  logic use_flat = 1'b0;
  pmm_pkg::pmm_side_in_type side = 2'b01;
  pmm_pkg::pmm_side_out_type o_side;
  int errors = 0;
  int tests_run = 0;
  // open-drain data line with pull-up
  assign sda = !(pull || o_sda_oe);
  // unpaged build sits on a data wire of its own
  assign sda_flat = !(pull || oe_flat);
  assign host_sda = use_flat ? sda_flat : sda;
  always #25 i_clk_sys = ~i_clk_sys;
  pmm_paged_mem pmm_paged_mem_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_wire({scl, sda}), .i_side(side), .i_int_event(i_int_event),
    .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_side(o_side));
  pmm_paged_mem #(.PAGED(1'b0)) pmm_paged_mem_flat_inst (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_wire({scl, sda_flat}),
    .i_side(side), .i_int_event(i_int_event), .o_sda_out(),
    .o_sda_oe(oe_flat), .o_side());
  pmm_host pmm_host_inst (.i_clk(i_clk_sys), .i_sda(host_sda), .o_scl(scl),
    .o_pull(pull));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic send(input logic [7:0] d, input logic ack_exp);
    logic ack;
    pmm_host_inst.wbyte(d, ack);
    chk(8'(ack), 8'(ack_exp));
  endtask : send
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    pmm_host_inst.start();
    send({pmm_pkg::DEV_ADDR, 1'b0}, 1'b1);
    send(a, 1'b1);
    send(d, 1'b1);
    pmm_host_inst.stop();
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    pmm_host_inst.start();
    send({pmm_pkg::DEV_ADDR, 1'b0}, 1'b1);
    send(a, 1'b1);
    pmm_host_inst.start();
    send({pmm_pkg::DEV_ADDR, 1'b1}, 1'b1);
    pmm_host_inst.rbyte(1'b0, d);
    pmm_host_inst.stop();
    chk(d, e);
  endtask : rd
  // lower byte, presence, foreign bus address ignored
  task automatic t_lower();
    chk(8'(o_side.present), 8'h01);
    wr(8'h05, 8'hab);
    pmm_host_inst.start();
    send({pmm_pkg::DEV_ADDR ^ 7'h01, 1'b0}, 1'b0);
    pmm_host_inst.stop();
    rd(8'h05, 8'hab);
  endtask : t_lower
  // each implemented page keeps its own top byte
  task automatic t_pages();
    logic [7:0] pg [5] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h11};
    foreach (pg[i])
    begin
      wr(8'h7f, pg[i]);
      wr(8'hff, pg[i] ^ 8'h5a);
    end
    foreach (pg[i])
    begin
      wr(8'h7f, pg[i]);
      rd(8'hff, pg[i] ^ 8'h5a);
      rd(8'h05, 8'hab);
    end
  endtask : t_pages
  // two-byte write and read, pointer steps by one per byte
  task automatic t_burst();
    logic [7:0] d0;
    logic [7:0] d1;
    wr(8'h7f, 8'h00);
    pmm_host_inst.start();
    send({pmm_pkg::DEV_ADDR, 1'b0}, 1'b1);
    send(8'hfe, 1'b1);
    send(8'h11, 1'b1);
    send(8'h22, 1'b1);
    pmm_host_inst.stop();
    pmm_host_inst.start();
    send({pmm_pkg::DEV_ADDR, 1'b0}, 1'b1);
    send(8'hfe, 1'b1);
    pmm_host_inst.start();
    send({pmm_pkg::DEV_ADDR, 1'b1}, 1'b1);
    pmm_host_inst.rbyte(1'b1, d0);
    pmm_host_inst.rbyte(1'b0, d1);
    pmm_host_inst.stop();
    chk(d0, 8'h11);
    chk(d1, 8'h22);
  endtask : t_burst
  // unpaged build: every page number maps to the one upper page
  task automatic t_flat();
    use_flat = 1'b1;
    wr(8'h7f, 8'h02);
    wr(8'hff, 8'h3c);
    wr(8'h7f, 8'h11);
    wr(8'h7e, 8'h01);
    rd(8'hff, 8'h3c);
    rd(8'h7f, 8'h11);
    use_flat = 1'b0;
  endtask : t_flat
  // missing page and other bank read blank
  task automatic t_unimpl();
    wr(8'h7f, 8'h03);
    wr(8'hff, 8'h77);
    rd(8'hff, 8'h00);
    wr(8'h7f, 8'h10);
    wr(8'h7e, 8'h01);
    rd(8'hff, 8'h00);
    wr(8'h7e, 8'h00);
    rd(8'hff, 8'h4a);
  endtask : t_unimpl
  // interrupt raised, read out and cleared by the read
  task automatic t_int();
    i_int_event = 1'b1;
    pmm_host_inst.q(1);
    i_int_event = 1'b0;
    pmm_host_inst.q(1);
    chk(8'(o_side.int_req), 8'h01);
    rd(8'h03, 8'h01);
    chk(8'(o_side.int_req), 8'h00);
  endtask : t_int
  // sideband low power and host reset, memory cleared
  task automatic t_side();
    side.low_power_req = 1'b1;
    pmm_host_inst.q(4);
    chk(8'(o_side.low_power_mode), 8'h01);
    side = 2'b00;
    pmm_host_inst.q(4);
    chk(8'(o_side.low_power_mode), 8'h00);
    chk(8'(o_side.module_reset), 8'h01);
    side.reset_n = 1'b1;
    pmm_host_inst.q(4);
    chk(8'(o_side.module_reset), 8'h00);
    rd(8'h05, 8'h00);
  endtask : t_side
  task automatic finish_test();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  // main sequence
  initial
  begin
    repeat (20) @(negedge i_clk_sys);
    i_rst = 1'b0;
    pmm_host_inst.q(4);
    t_lower();
    t_pages();
    t_burst();
    t_unimpl();
    t_flat();
    t_int();
    t_side();
    finish_test();
  end
  // watchdog against a hung bus
  initial
  begin
    #3000000;
    errors++;
    finish_test();
  end
endmodule : testbench
`default_nettype wire
